// >>> dv/tpfc_timer_tb.sv
// testbench: register access and dual-slope pwm checks of tpfc_timer
`timescale 1ns/1ps
module tpfc_timer_tb import tpfc_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic timer_tick_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h00000000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic irq_o;
  logic compare_a_o;
  logic compare_b_o;
  int error_cnt = 0;
  int comparisons = 0;
  // ****************************************************************
  // reference model, kept in step with every tick and write
  // ****************************************************************
  logic [15:0] cnt = 16'h0000;
  logic [15:0] buf_a = 16'h0000;
  logic [15:0] buf_b = 16'h0000;
  logic [15:0] act_a = 16'h0000;
  logic [15:0] act_b = 16'h0000;
  logic [15:0] cap = 16'hFFFF;
  logic [15:0] top;
  logic [3:0] st = 4'h0;
  logic [3:0] mask = 4'h0;
  logic [8:0] ctrl = 9'h000;
  logic up = 1'b1;
  logic wa = 1'b0;
  logic wb = 1'b0;
  logic m89 = 1'b0;

  always #20 clk_sys_i = ~clk_sys_i;

  tpfc_timer #(.CNT_W(16)) tpfc_timer_i (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .timer_tick_i(timer_tick_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o),
    .compare_a_o(compare_a_o),
    .compare_b_o(compare_b_o)
  );
  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    if (a == TPFC_REG_CTRL) ctrl = d[8:0];
    if (a == TPFC_REG_COUNT) cnt = d[15:0];
    if (a == TPFC_REG_CMP_A) buf_a = d[15:0];
    if (a == TPFC_REG_CMP_B) buf_b = d[15:0];
    if (a == TPFC_REG_CAPTOP) cap = d[15:0];
    if (a == TPFC_REG_MASK) mask = d[3:0];
    if (a == TPFC_REG_STATUS) st = st & ~d[3:0];
    m89 = ctrl[3:0] == TPFC_MODE_ICR_TOP || ctrl[3:0] == TPFC_MODE_OCRA_TOP;
    // outside the pwm modes the active compares follow the buffers
    if (!m89) begin
      act_a = buf_a;
      act_b = buf_b;
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask

  // one timer tick, then the model advances as the hardware should
  task step();
    @(posedge clk_sys_i);
    timer_tick_i <= 1'b1;
    @(posedge clk_sys_i);
    timer_tick_i <= 1'b0;
    if (m89 && ctrl[TPFC_CTRL_RUN_BIT]) begin
      top = (ctrl[3:0] == TPFC_MODE_ICR_TOP) ? cap : act_a;
      if (cnt == act_a) begin
        st[TPFC_ST_CMPA] = 1'b1;
        wa = up ? ctrl[TPFC_CTRL_INV_A_BIT] : ~ctrl[TPFC_CTRL_INV_A_BIT];
      end
      if (cnt == act_b) begin
        st[TPFC_ST_CMPB] = 1'b1;
        wb = up ? ctrl[TPFC_CTRL_INV_B_BIT] : ~ctrl[TPFC_CTRL_INV_B_BIT];
      end
      if (up && cnt == top) begin
        if (ctrl[3:0] == TPFC_MODE_ICR_TOP) st[TPFC_ST_CAP] = 1'b1;
        else st[TPFC_ST_CMPA] = 1'b1;
        up = 1'b0;
        cnt = cnt - 16'h0001;
      end else if (up) begin
        cnt = cnt + 16'h0001;
      end else if (cnt == TPFC_BOTTOM) begin
        act_a = buf_a;
        act_b = buf_b;
        st[TPFC_ST_OVF] = 1'b1;
        up = 1'b1;
        cnt = 16'h0001;
      end else begin
        cnt = cnt - 16'h0001;
      end
    end
  endtask

  task check_state(input logic w);
    rd(TPFC_REG_COUNT, {16'h0000, cnt});
    rd(TPFC_REG_STATUS, {28'h0000000, st});
    chk(32'(irq_o), 32'(|(st & mask)));
    if (w) begin
      chk(32'(compare_a_o), 32'(wa & ctrl[TPFC_CTRL_OUTEN_A_BIT]));
      chk(32'(compare_b_o), 32'(wb & ctrl[TPFC_CTRL_OUTEN_B_BIT]));
    end
  endtask

  task print_verdict();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4), (i == 4) ? 32'h0000FFFF : 32'h00000000);
    end
    wr(TPFC_REG_CAPTOP, 32'h00000005);
    wr(TPFC_REG_CMP_A, 32'h00000002);
    wr(TPFC_REG_CMP_B, 32'h00000003);
    wr(TPFC_REG_MASK, 32'h00000001);
    // mode 8 with no clock selected first: the counter must stay put
    wr(TPFC_REG_CTRL, 32'h000000C8);
    repeat (3) step();
    check_state(1'b1);
    wr(TPFC_REG_CTRL, 32'h000001D0);
    repeat (3) step();
    check_state(1'b1);
    wr(TPFC_REG_CTRL, 32'h000001D8);
    for (int i = 0; i < 12; i++) begin
      step();
      check_state(1'b1);
      if (i == 2) begin
        wr(TPFC_REG_CMP_A, 32'h00000004);
        rd(TPFC_REG_CMP_A, 32'h00000004);
      end
    end
    wr(TPFC_REG_STATUS, 32'h0000000F);
    check_state(1'b1);
    wr(TPFC_REG_CTRL, 32'h000001D9);
    for (int i = 0; i < 10; i++) begin
      step();
      check_state(1'b1);
    end
    // counter write while running, then counting goes on from there
    wr(TPFC_REG_COUNT, 32'h00000001);
    step();
    check_state(1'b1);
    // unmapped offset: write ignored, read gives zero
    wr(8'h1C, 32'hFFFFFFFF);
    rd(8'h1C, 32'h00000000);
    print_verdict();
  end

  // run needs about 210 cycles; cut off a hang well beyond that
  initial begin
    #200000;
    error_cnt++;
    print_verdict();
  end
endmodule

// >>> src/tpfc_pkg.sv
// package: register map, field layout and reset values of the pwm timer
package tpfc_pkg;
  // ****************************************************************
  // register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] TPFC_REG_CTRL = 8'h00;
  localparam logic [7:0] TPFC_REG_COUNT = 8'h04;
  localparam logic [7:0] TPFC_REG_CMP_A = 8'h08;
  localparam logic [7:0] TPFC_REG_CMP_B = 8'h0C;
  localparam logic [7:0] TPFC_REG_CAPTOP = 8'h10;
  localparam logic [7:0] TPFC_REG_STATUS = 8'h14;
  localparam logic [7:0] TPFC_REG_MASK = 8'h18;
  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int TPFC_CTRL_MODE_LSB = 0;
  localparam int TPFC_CTRL_RUN_BIT = 4;
  localparam int TPFC_CTRL_INV_A_BIT = 5;
  localparam int TPFC_CTRL_INV_B_BIT = 6;
  localparam int TPFC_CTRL_OUTEN_A_BIT = 7;
  localparam int TPFC_CTRL_OUTEN_B_BIT = 8;
  localparam logic [3:0] TPFC_MODE_ICR_TOP = 4'h8;
  localparam logic [3:0] TPFC_MODE_OCRA_TOP = 4'h9;
  // ****************************************************************
  // status and mask bits
  // ****************************************************************
  localparam int TPFC_ST_OVF = 0;
  localparam int TPFC_ST_CMPA = 1;
  localparam int TPFC_ST_CMPB = 2;
  localparam int TPFC_ST_CAP = 3;
  localparam int TPFC_ST_W = 4;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] TPFC_RST_COUNT = 16'h0000;
  localparam logic [15:0] TPFC_RST_CMP = 16'h0000;
  localparam logic [15:0] TPFC_RST_CAPTOP = 16'hFFFF;
  localparam logic [15:0] TPFC_BOTTOM = 16'h0000;
  localparam logic [8:0] TPFC_RST_CTRL = 9'h000;
endpackage

// >>> src/tpfc_timer.sv
// dual-slope phase and frequency correct pwm timer, top level
`timescale 1ns/1ps
module tpfc_timer
  import tpfc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic timer_tick_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  output logic compare_a_o,
  output logic compare_b_o
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [8:0] ctrl;
    logic [CNT_W-1:0] count;
    logic up;
    logic [CNT_W-1:0] buf_a;
    logic [CNT_W-1:0] buf_b;
    logic [CNT_W-1:0] act_a;
    logic [CNT_W-1:0] act_b;
    logic [CNT_W-1:0] captop;
    logic [TPFC_ST_W-1:0] status;
    logic [TPFC_ST_W-1:0] mask;
    logic [31:0] rdata;
    logic irq;
  } tpfc_state_t;
  tpfc_state_t st;
  tpfc_state_t next_st;

  logic [3:0] mode;
  logic pwm_on;
  logic tick;
  logic [CNT_W-1:0] top;
  logic at_top;
  logic at_bottom;
  logic match_a;
  logic match_b;
  logic [TPFC_ST_W-1:0] ev;
  logic wave_a;
  logic wave_b;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  function automatic logic [31:0] tpfc_zx(input logic [CNT_W-1:0] v);
    tpfc_zx = 32'(v);
  endfunction

  assign mode = st.ctrl[TPFC_CTRL_MODE_LSB +: 4];
  assign pwm_on = (mode == TPFC_MODE_ICR_TOP) ||
                  (mode == TPFC_MODE_OCRA_TOP);
  // no clock selected keeps the counter frozen
  assign tick = timer_tick_i & st.ctrl[TPFC_CTRL_RUN_BIT] & pwm_on;
  assign top = (mode == TPFC_MODE_OCRA_TOP) ? st.act_a : st.captop;
  assign at_top = (st.count == top);
  assign at_bottom = (st.count == TPFC_BOTTOM);
  assign match_a = tick & (st.count == st.act_a);
  assign match_b = tick & (st.count == st.act_b);

  always_comb begin
    ev = '0;
    ev[TPFC_ST_CMPA] = match_a;
    ev[TPFC_ST_CMPB] = match_b;
    if (tick && at_top) begin
      // the top-defining register's flag marks top
      if (mode == TPFC_MODE_OCRA_TOP) begin
        ev[TPFC_ST_CMPA] = 1'b1;
      end else begin
        ev[TPFC_ST_CAP] = 1'b1;
      end
    end
    ev[TPFC_ST_OVF] = tick & at_bottom & ~st.up;
  end

  // ****************************************************************
  // counter, buffers and registers
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.rdata = '0;
    if (tick) begin
      if (st.up) begin
        if (at_top) begin
          // top held one tick; direction turns here
          next_st.up = 1'b0;
          next_st.count = st.count - CNT_ONE;
        end else begin
          next_st.count = st.count + CNT_ONE;
        end
      end else if (at_bottom) begin
        // bottom: load buffered compares; in mode 9 top stays stable mid-period
        next_st.act_a = st.buf_a;
        next_st.act_b = st.buf_b;
        next_st.up = 1'b1;
        next_st.count = st.count + CNT_ONE;
      end else begin
        next_st.count = st.count - CNT_ONE;
      end
    end
    if (!pwm_on) begin
      next_st.act_a = st.buf_a;
      next_st.act_b = st.buf_b;
    end
    // clear by writing one; a same-cycle event wins
    if (reg_wr_i && reg_addr_i == TPFC_REG_STATUS) begin
      next_st.status = st.status & ~reg_wdata_i[TPFC_ST_W-1:0];
    end
    next_st.status = next_st.status | ev;
    if (reg_wr_i) begin
      case (reg_addr_i)
        TPFC_REG_CTRL: next_st.ctrl = reg_wdata_i[8:0];
        TPFC_REG_COUNT: begin
          next_st.count = reg_wdata_i[CNT_W-1:0];
        end
        TPFC_REG_CMP_A: next_st.buf_a = reg_wdata_i[CNT_W-1:0];
        TPFC_REG_CMP_B: next_st.buf_b = reg_wdata_i[CNT_W-1:0];
        TPFC_REG_CAPTOP: begin
          // top range of 3 up to max is left to software
          next_st.captop = reg_wdata_i[CNT_W-1:0];
        end
        TPFC_REG_MASK: next_st.mask = reg_wdata_i[TPFC_ST_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        TPFC_REG_CTRL: next_st.rdata = 32'(st.ctrl);
        TPFC_REG_COUNT: next_st.rdata = tpfc_zx(st.count);
        TPFC_REG_CMP_A: next_st.rdata = tpfc_zx(st.buf_a);
        TPFC_REG_CMP_B: next_st.rdata = tpfc_zx(st.buf_b);
        TPFC_REG_CAPTOP: next_st.rdata = tpfc_zx(st.captop);
        TPFC_REG_STATUS: next_st.rdata = 32'(st.status);
        TPFC_REG_MASK: next_st.rdata = 32'(st.mask);
        default: next_st.rdata = '0;
      endcase
    end
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st.ctrl <= TPFC_RST_CTRL;
      st.count <= TPFC_RST_COUNT;
      st.up <= 1'b1;
      st.buf_a <= TPFC_RST_CMP;
      st.buf_b <= TPFC_RST_CMP;
      st.act_a <= TPFC_RST_CMP;
      st.act_b <= TPFC_RST_CMP;
      st.captop <= TPFC_RST_CAPTOP;
      st.status <= '0;
      st.mask <= '0;
      st.rdata <= '0;
      st.irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // waveform units
  // ****************************************************************
  tpfc_wave u_wave_a (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .match_i(match_a),
    .counting_up_i(st.up),
    .inverted_i(st.ctrl[TPFC_CTRL_INV_A_BIT]),
    .enable_i(st.ctrl[TPFC_CTRL_OUTEN_A_BIT]),
    .wave_o(wave_a)
  );
  tpfc_wave u_wave_b (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .match_i(match_b),
    .counting_up_i(st.up),
    .inverted_i(st.ctrl[TPFC_CTRL_INV_B_BIT]),
    .enable_i(st.ctrl[TPFC_CTRL_OUTEN_B_BIT]),
    .wave_o(wave_b)
  );

  assign reg_rdata_o = st.rdata;
  assign irq_o = st.irq;
  assign compare_a_o = wave_a;
  assign compare_b_o = wave_b;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_MODE_GATE: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !pwm_on |=> $stable(st.count) || $past(reg_wr_i))
    else $error("counter moved outside pwm modes");

  AST_UP_STEP: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tick && st.up && !at_top && !reg_wr_i
    |=> st.count == $past(st.count) + CNT_ONE)
    else $error("up step wrong");

  AST_DOWN_STEP: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tick && !st.up && !at_bottom && !reg_wr_i
    |=> st.count == $past(st.count) - CNT_ONE)
    else $error("down step wrong");

  AST_BOTTOM_TURN: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tick && !st.up && at_bottom && !reg_wr_i
    |=> st.up && st.count == CNT_ONE)
    else $error("no turn at bottom");

  AST_TOP_TURN: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tick && st.up && at_top && !reg_wr_i
    |=> !st.up && st.count == $past(st.count) - CNT_ONE)
    else $error("no turn at top");

  AST_TOP_SRC: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tick && st.up && mode == TPFC_MODE_ICR_TOP && st.count == st.captop
    |=> !st.up)
    else $error("mode 8 did not turn at capture top");

  AST_TOP_SRC_A: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tick && st.up && mode == TPFC_MODE_OCRA_TOP && st.count == st.act_a
    |=> !st.up)
    else $error("mode 9 did not turn at compare a");

  AST_CMP_FLAG: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    match_b |=> st.status[TPFC_ST_CMPB])
    else $error("compare b flag missed");

  AST_CMPA_FLAG: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    match_a |=> st.status[TPFC_ST_CMPA])
    else $error("compare a flag missed");

  AST_BOTTOM_LOAD: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tick && !st.up && at_bottom && !reg_wr_i
    |=> st.act_a == $past(st.buf_a) && st.status[TPFC_ST_OVF])
    else $error("bottom load or overflow missed");

  AST_BOTTOM_LOAD_B: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tick && !st.up && at_bottom && !reg_wr_i
    |=> st.act_b == $past(st.buf_b))
    else $error("bottom load of compare b missed");

  AST_SET_WINS: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ev != '0 |=> (st.status & $past(ev)) == $past(ev))
    else $error("flag event lost against a clear");

  AST_TOP_FLAG: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tick && at_top && mode == TPFC_MODE_ICR_TOP
    |=> st.status[TPFC_ST_CAP])
    else $error("capture flag missed at top");

  AST_TOP_FLAG_A: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tick && at_top && mode == TPFC_MODE_OCRA_TOP
    |=> st.status[TPFC_ST_CMPA])
    else $error("compare a flag missed at top");

  AST_BUF_WRITE: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == TPFC_REG_CMP_A && pwm_on && !tick
    |=> $stable(st.act_a))
    else $error("write reached active compare a");

  AST_BUF_WRITE_B: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == TPFC_REG_CMP_B && pwm_on && !tick
    |=> $stable(st.act_b))
    else $error("write reached active compare b");

  AST_BUF_LAND_A: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == TPFC_REG_CMP_A
    |=> st.buf_a == $past(reg_wdata_i[CNT_W-1:0]))
    else $error("compare a write missed the buffer");

  AST_HOLD_IDLE: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !timer_tick_i && !reg_wr_i |=> $stable(st.count))
    else $error("counter moved without tick");

  AST_TICK_GATE: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !st.ctrl[TPFC_CTRL_RUN_BIT] && !reg_wr_i |=> $stable(st.count))
    else $error("counter moved with no clock selected");

  AST_NO_TICK_FLAGS: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !tick && !reg_wr_i |=> $stable(st.status))
    else $error("flags moved without tick");
endmodule

// >>> src/tpfc_wave.sv
// one compare output unit: set/clear of the waveform on a match
`timescale 1ns/1ps
module tpfc_wave
  import tpfc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic match_i,
  input wire logic counting_up_i,
  input wire logic inverted_i,
  input wire logic enable_i,
  output logic wave_o
);
  typedef struct packed {
    logic wave;
    logic drive;
  } tpfc_wave_t;
  tpfc_wave_t st;
  tpfc_wave_t next_st;

  always_comb begin
    next_st = st;
    if (match_i) begin
      // up match clears when non-inverting, sets when inverting
      if (counting_up_i) begin
        next_st.wave = inverted_i;
      end else begin
        next_st.wave = ~inverted_i;
      end
    end
    // gated in the flop so the pin is a register; enable lands a cycle late
    next_st.drive = next_st.wave & enable_i;
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign wave_o = st.drive;

  AST_UP_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    match_i && counting_up_i && !inverted_i |=> !st.wave)
    else $error("up match did not clear the wave");
  AST_DOWN_SET: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    match_i && !counting_up_i && !inverted_i |=> st.wave)
    else $error("down match did not set the wave");
  AST_INV_UP_SET: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    match_i && counting_up_i && inverted_i |=> st.wave)
    else $error("inverted up match did not set the wave");
  AST_INV_DOWN_CLEAR: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    match_i && !counting_up_i && inverted_i |=> !st.wave)
    else $error("inverted down match did not clear the wave");
endmodule
